// ### rtl/term_cmd_pkg.sv
// Package for the input terminal command decoder: function codes, widths, timing.
// Assumes a single 125 MHz control clock.
package term_cmd_pkg;
  localparam int N_TERM = 12;
  localparam int FUNC_W = 7;
  localparam int FREQ_W = 16;
  localparam int SRC_W = 4;
  localparam int CLK_HZ = 125000000;
  localparam int RUN_HOLD_US = 2000;
  localparam int RUN_HOLD_CYC = (RUN_HOLD_US * (CLK_HZ / 1000000)) + 1;
  localparam int CNT_W = 18;
  localparam logic [FUNC_W-1:0] FN_DIRECT = 7'h00;
  localparam logic [FUNC_W-1:0] FN_THREE_WIRE = 7'h01;
  localparam logic [FUNC_W-1:0] FN_LOCAL_REMOTE_KEY = 7'h02;
  localparam logic [FUNC_W-1:0] FN_SRC_SW = 7'h03;
  localparam logic [FUNC_W-1:0] FN_FWD = 7'h04;
  localparam logic [FUNC_W-1:0] FN_REV = 7'h05;
  localparam logic [FUNC_W-1:0] FN_RUN2 = 7'h06;
  localparam logic [FUNC_W-1:0] FN_DIR2 = 7'h07;
  localparam logic [FUNC_W-1:0] FN_MS1 = 7'h08;
  localparam logic [FUNC_W-1:0] FN_JOG = 7'h0c;
  localparam logic [FUNC_W-1:0] FN_INIT_FIRST = 7'h04;
  localparam logic [FUNC_W-1:0] FN_INIT_SECOND = 7'h05;
  localparam logic RST_LOCAL = 1'b0;
  localparam logic RST_SRC_B = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } tw_state_type;
endpackage

// ### rtl/input_terminal_command_decoder.sv
// Decodes the twelve multi-function contact terminals into run, direction, source,
// local/remote and speed selection. Contacts are taken as synchronous, already debounced.
//
// Overview of operation
// R01: A three-wire terminal beyond the first two makes first=run, second=stop, itself=direction.
// R02: Three-wire start needs the run contact closed for more than 2 ms.
// R03: Three-wire stop contact opening stops output at once.
// R04: Three-wire direction terminal open means forward, closed means reverse.
// R05: Power-on run permit 0 blocks start with run present and flags protection; 1 allows. Here a latched three-wire start runs once the run contact opens.
// R06: Local/remote terminal sets mode by its state; keypad local/remote key stays valid.
// R07: While run is commanded, local/remote changes are ignored.
// R08: Source switch open picks source pair A, closed picks pair B.
// R09: Active command source holds while a run command is present.
// R10: Function 4 closed runs forward, 5 closed runs reverse; open stops.
// R11: First two-wire mode stops when forward and reverse agree.
// R12: Configuration never mixes functions 4 or 5 with 6 or 7.
// R13: Initialization to two-wire gives first terminal forward, second reverse.
// R14: Function 6 runs while closed; function 7 picks reverse when closed, inert when stopped.
// R15: Functions 8 to 11 form a selector; all open keeps the other frequency.
// R16: Selector is binary, bit 1 least significant; code n picks preset n.
// R17: All preset segments share the one multi-speed ramp time.
// R18: Jog select closed makes the jog preset the effective frequency.
// R19: Function 0 drives nothing; its contact passes through.
// R20: Local mode lights the local-command indication.
// R21: Polarity bit 0 takes closed as active, 1 inverts the terminal first.
// R22: Each terminal has its own function code 0 to 99.
// R23: Reserved or unhandled codes affect no run, direction or speed output.
module input_terminal_command_decoder
  import term_cmd_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Terminal contacts and configuration
  input wire logic [N_TERM-1:0] i_contacts,
  input wire logic [N_TERM-1:0] i_terminal_polarity_bits,
  input wire logic [N_TERM*FUNC_W-1:0] i_func_codes,
  input wire logic i_init_two_wire,
  // Run control settings
  input wire logic i_power_on_run_permit,
  input wire logic i_local_remote_key,
  input wire logic [SRC_W-1:0] i_speed_source_sel_a,
  input wire logic [SRC_W-1:0] i_run_source_sel_a,
  input wire logic [SRC_W-1:0] i_speed_source_sel_b,
  input wire logic [SRC_W-1:0] i_run_source_sel_b,
  // Frequency settings
  input wire logic [FREQ_W-1:0] i_base_freq,
  input wire logic [FREQ_W-1:0] i_jog_speed_preset,
  input wire logic [15*FREQ_W-1:0] i_preset_speed_table,
  input wire logic [FREQ_W-1:0] i_multispeed_ramp_time,
  input wire logic [FREQ_W-1:0] i_ramp_time_normal,
  // Command outputs
  output logic o_run,
  output logic o_reverse,
  output logic o_protect,
  output logic o_local,
  output logic o_local_indication,
  output logic [SRC_W-1:0] o_speed_source,
  output logic [SRC_W-1:0] o_run_source,
  output logic [FREQ_W-1:0] o_freq,
  output logic [FREQ_W-1:0] o_ramp_time,
  output logic [3:0] o_speed_code,
  output logic o_jog,
  output logic [N_TERM-1:0] o_passthru,
  output logic o_init_apply,
  output logic [FUNC_W-1:0] o_init_first_func,
  output logic [FUNC_W-1:0] o_init_second_func
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [FUNC_W-1:0] code_of(input logic [N_TERM*FUNC_W-1:0] codes,
                                                input int idx);
    code_of = codes[idx*FUNC_W +: FUNC_W];
  endfunction

  // Any terminal of one function whose contact is active
  function automatic logic any_act(input logic [N_TERM-1:0] sel, input logic [N_TERM-1:0] a);
    any_act = |(sel & a);
  endfunction

  logic [N_TERM-1:0] act;
  logic [N_TERM-1:0] is_three, is_locrem, is_srcsw, is_fwd, is_rev, is_run2, is_dir2;
  logic [N_TERM-1:0] is_jog, is_direct;
  logic [N_TERM-1:0] is_ms [4];

  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      assign act[g] = i_contacts[g] ^ i_terminal_polarity_bits[g]; // R21
      // Codes outside the handled set simply match nothing
      assign is_direct[g] = code_of(i_func_codes, g) == FN_DIRECT; // R22 R23
      assign is_three[g] = (g > 1) && code_of(i_func_codes, g) == FN_THREE_WIRE; // R01
      assign is_locrem[g] = code_of(i_func_codes, g) == FN_LOCAL_REMOTE_KEY;
      assign is_srcsw[g] = code_of(i_func_codes, g) == FN_SRC_SW;
      assign is_fwd[g] = code_of(i_func_codes, g) == FN_FWD;
      assign is_rev[g] = code_of(i_func_codes, g) == FN_REV;
      assign is_run2[g] = code_of(i_func_codes, g) == FN_RUN2;
      assign is_dir2[g] = code_of(i_func_codes, g) == FN_DIR2;
      assign is_jog[g] = code_of(i_func_codes, g) == FN_JOG;
      for (genvar b = 0; b < 4; b++) begin : g_ms
        assign is_ms[b][g] = code_of(i_func_codes, g) == FN_MS1 + FUNC_W'(b); // R15
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection and combined commands

  logic three_mode, two_mode2;
  logic tw_run_in, tw_stop_ok, tw_dir;
  logic fwd_in, rev_in, run2_in, dir2_in;
  logic [3:0] sel_code;
  logic run_cmd_in;
  logic run_next, rev_next;

  assign three_mode = |is_three;
  assign two_mode2 = |is_run2; // R12
  assign tw_run_in = act[0];
  assign tw_stop_ok = act[1];
  assign tw_dir = |(is_three & act); // R04
  assign fwd_in = |(is_fwd & act); // R10
  assign rev_in = |(is_rev & act); // R10
  assign run2_in = |(is_run2 & act); // R14
  assign dir2_in = |(is_dir2 & act);
  logic locrem_act, srcsw_act, jog_act;
  assign locrem_act = any_act(is_locrem, act); // R06
  assign srcsw_act = any_act(is_srcsw, act); // R08
  assign jog_act = any_act(is_jog, act); // R18
  generate
    for (g = 0; g < 4; g++) begin : g_sel
      assign sel_code[g] = |(is_ms[g] & act); // R16
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Three-wire run latch with 2 ms qualification

  tw_state_type tw_state_reg;
  logic [CNT_W-1:0] hold_cnt_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !three_mode || !tw_stop_ok) begin
      tw_state_reg <= ST_IDLE; // R03
      hold_cnt_reg <= '0;
    end else begin
      case (tw_state_reg)
        ST_IDLE: begin
          if (tw_run_in) begin
            tw_state_reg <= ST_ARM;
            hold_cnt_reg <= CNT_W'(1);
          end
        end
        ST_ARM: begin
          if (!tw_run_in) begin
            tw_state_reg <= ST_IDLE;
            // Counting from the first closed edge keeps the hold strictly above 2 ms
          end else if (hold_cnt_reg >= CNT_W'(RUN_HOLD_CYC - 1)) begin
            tw_state_reg <= ST_RUN; // R02
          end else begin
            hold_cnt_reg <= hold_cnt_reg + CNT_W'(1);
          end
        end
        // A start latches; only the stop contact or leaving the mode ends it
        ST_RUN: tw_state_reg <= ST_RUN;
        default: tw_state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run and direction per decoding mode

  always_comb begin
    if (three_mode) begin
      run_next = tw_stop_ok && tw_state_reg == ST_RUN; // R03
      rev_next = tw_dir; // R04
    end else if (two_mode2) begin
      run_next = run2_in; // R14
      rev_next = run2_in ? dir2_in : o_reverse;
    end else begin
      run_next = fwd_in ^ rev_in; // R11
      rev_next = rev_in && !fwd_in;
    end
  end

  // Any run input, used to freeze mode and source changes
  assign run_cmd_in = three_mode ? tw_run_in : (fwd_in | rev_in | run2_in);

  ////////////////////////////////////////////////////////////////////////////
  // Power-on permission: a run already present after reset is blocked until the run inputs go idle

  logic armed_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      armed_reg <= 1'b0;
      o_protect <= 1'b0;
    end else if (!armed_reg) begin
      // Holding off until the run inputs go idle avoids a surprise two-wire start at power-up; a latched three-wire start runs once armed
      if (!run_cmd_in || i_power_on_run_permit) begin
        armed_reg <= 1'b1; // R05
        o_protect <= 1'b0;
      end else begin
        o_protect <= 1'b1; // R05
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered run, gated by the power-on permission, and ungated registered direction

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_run <= 1'b0;
      o_reverse <= 1'b0;
    end else begin
      o_run <= armed_reg && run_next;
      o_reverse <= rev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local/remote and command source, frozen while run is commanded

  logic key_prev_reg;
  logic locrem_prev_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_local <= RST_LOCAL;
      o_local_indication <= RST_LOCAL;
      key_prev_reg <= 1'b0;
      locrem_prev_reg <= 1'b0;
    end else begin
      key_prev_reg <= i_local_remote_key;
      // Last terminal state advances only while free, so a change made in run lands after it
      if (!run_cmd_in && !o_run) begin // R07
        locrem_prev_reg <= locrem_act;
        if (|is_locrem && (locrem_act != locrem_prev_reg)) begin
          o_local <= locrem_act; // R06
          o_local_indication <= locrem_act; // R20
        end else if (i_local_remote_key && !key_prev_reg) begin
          o_local <= !o_local; // R06
          o_local_indication <= !o_local; // R20
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command source pair, same freeze as local/remote

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_speed_source <= '0;
      o_run_source <= '0;
    end else if (!run_cmd_in && !o_run) begin // R09
      o_speed_source <= srcsw_act ? i_speed_source_sel_b : i_speed_source_sel_a; // R08
      o_run_source <= srcsw_act ? i_run_source_sel_b : i_run_source_sel_a; // R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frequency selection, jog first, then presets, else base

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_freq <= '0;
      o_ramp_time <= '0;
      o_speed_code <= 4'h0;
      o_jog <= 1'b0;
    end else begin
      o_speed_code <= sel_code;
      o_jog <= jog_act;
      if (jog_act) begin
        o_freq <= i_jog_speed_preset; // R18
        o_ramp_time <= i_ramp_time_normal;
      end else if (sel_code != 4'h0) begin
        o_freq <= i_preset_speed_table[(sel_code - 4'h1)*FREQ_W +: FREQ_W]; // R16
        o_ramp_time <= i_multispeed_ramp_time; // R17
      end else begin
        o_freq <= i_base_freq; // R15
        o_ramp_time <= i_ramp_time_normal;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pass-through contacts and two-wire initialization values

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_passthru <= '0;
      o_init_apply <= 1'b0;
      o_init_first_func <= FN_INIT_FIRST;
      o_init_second_func <= FN_INIT_SECOND;
    end else begin
      o_passthru <= act & is_direct; // R19
      o_init_apply <= i_init_two_wire; // R13
      o_init_first_func <= FN_INIT_FIRST; // R13
      o_init_second_func <= FN_INIT_SECOND;
    end
  end

endmodule

// ### test/contact_model.sv
// Contact model for the terminal switches and relays.
// Assumes the bench gives the wanted contact state on i_press.
module contact_model (
  // Clock
  input wire logic i_ref_clk,
  // Wanted and actual contact state
  input wire logic [11:0] i_press,
  output logic [11:0] o_contacts
);
  timeunit 1ns;
  timeprecision 1ps;
  // Relays settle a clock late, so the bench never sees a same-edge change
  always_ff @(posedge i_ref_clk) begin
    o_contacts <= i_press;
  end
endmodule

// ### test/term_cmd_checker_properties.sv
// Checker for the terminal command decoder outputs.
// Assumes it is bound to the decoder and sees its ports only.
module term_cmd_checker
  import term_cmd_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Watched inputs
  input wire logic [N_TERM-1:0] i_contacts,
  input wire logic [N_TERM-1:0] i_terminal_polarity_bits,
  input wire logic [N_TERM*FUNC_W-1:0] i_func_codes,
  input wire logic i_power_on_run_permit,
  input wire logic [FREQ_W-1:0] i_jog_speed_preset,
  input wire logic [15*FREQ_W-1:0] i_preset_speed_table,
  input wire logic [FREQ_W-1:0] i_multispeed_ramp_time,
  // Watched outputs
  input wire logic o_run,
  input wire logic o_protect,
  input wire logic o_local,
  input wire logic o_local_indication,
  input wire logic [FREQ_W-1:0] o_freq,
  input wire logic [FREQ_W-1:0] o_ramp_time,
  input wire logic [3:0] o_speed_code,
  input wire logic o_jog,
  input wire logic [N_TERM-1:0] o_passthru
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N_TERM-1:0] pass_now;
  logic three_now, stop_now;
  always_comb begin
    three_now = 1'b0;
    stop_now = i_contacts[1] ^ i_terminal_polarity_bits[1];
    for (int k = 0; k < N_TERM; k++) begin
      pass_now[k] = (i_func_codes[k*FUNC_W+:FUNC_W] == FN_DIRECT)
        & (i_contacts[k] ^ i_terminal_polarity_bits[k]);
      if (k > 1 && i_func_codes[k*FUNC_W+:FUNC_W] == FN_THREE_WIRE) three_now = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_local_ind: assert property (o_local_indication == o_local)
    else $error("indication differs");
  a_jog_freq: assert property (o_jog |-> o_freq == $past(i_jog_speed_preset))
    else $error("jog freq wrong");
  a_preset_freq: assert property (o_speed_code != 4'h0 && !o_jog |->
    o_freq == 16'($past(i_preset_speed_table) >> (FREQ_W * (o_speed_code - 4'h1))))
    else $error("preset freq wrong");
  a_preset_ramp: assert property (o_speed_code != 4'h0 && !o_jog |->
    o_ramp_time == $past(i_multispeed_ramp_time)) else $error("ramp wrong");
  a_prot_norun: assert property (o_protect |-> !o_run)
    else $error("run while blocked");
  a_prot_cause: assert property ($rose(o_protect) |-> !$past(i_power_on_run_permit))
    else $error("block with permit");
  a_pass_thru: assert property (!$past(i_sys_rst) |-> o_passthru == $past(pass_now))
    else $error("passthru wrong");
  a_local_hold: assert property (o_run && $past(o_run) |-> $stable(o_local))
    else $error("mode moved in run");
  a_three_stop: assert property ($past(three_now) && !$past(stop_now) |-> !o_run)
    else $error("run with stop open");
  c_jog: cover property (o_jog);
  c_prot: cover property (o_protect);
  c_local_run: cover property (o_local && o_run);
endmodule
bind input_terminal_command_decoder term_cmd_checker chk_inst (.i_ref_clk, .i_sys_rst,
  .i_contacts, .i_terminal_polarity_bits, .i_func_codes, .i_power_on_run_permit,
  .i_jog_speed_preset, .i_preset_speed_table, .i_multispeed_ramp_time, .o_run, .o_protect,
  .o_local, .o_local_indication, .o_freq, .o_ramp_time, .o_speed_code, .o_jog, .o_passthru);

// ### test/test_input_terminal_command_decoder.sv
// Bench for the terminal command decoder.
// Assumes the contact model in front and the bound checker.
module test_input_terminal_command_decoder
  import term_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_sys_rst = 1, i_init_two_wire = 0, i_power_on_run_permit = 1;
  logic i_local_remote_key = 0;
  logic [11:0] pr = 0, i_terminal_polarity_bits = 0, i_contacts;
  logic [6:0] fc [12];
  logic [83:0] i_func_codes;
  logic [15:0] i_base_freq = 16'h0123, i_jog_speed_preset = 16'h0777;
  logic [15:0] i_multispeed_ramp_time = 16'h0055, i_ramp_time_normal = 16'h0011;
  logic [239:0] i_preset_speed_table;
  logic [3:0] i_speed_source_sel_a = 4'h1, i_run_source_sel_a = 4'h2;
  logic [3:0] i_speed_source_sel_b = 4'h3, i_run_source_sel_b = 4'h4;
  logic o_run, o_reverse, o_protect, o_local, o_local_indication, o_jog, o_init_apply;
  logic [3:0] o_speed_source, o_run_source, o_speed_code;
  logic [15:0] o_freq, o_ramp_time, e, vw [15];
  logic [11:0] o_passthru;
  logic [6:0] o_init_first_func, o_init_second_func;
  logic [4:0] r;
  integer seed = 79;
  int failures = 0, num_checks = 0, f;
  logic [15:0] qe [$];
  int qf [$];
  event look;
  `define CMP(g, x) begin num_checks++; if ((g) !== (x)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x); end end
  contact_model contact_model_inst (.i_ref_clk, .i_press(pr), .o_contacts(i_contacts));
  input_terminal_command_decoder input_terminal_command_decoder_inst (.i_ref_clk, .i_sys_rst,
    .i_contacts, .i_terminal_polarity_bits, .i_func_codes, .i_init_two_wire,
    .i_power_on_run_permit, .i_local_remote_key, .i_speed_source_sel_a, .i_run_source_sel_a,
    .i_speed_source_sel_b, .i_run_source_sel_b, .i_base_freq, .i_jog_speed_preset,
    .i_preset_speed_table, .i_multispeed_ramp_time, .i_ramp_time_normal, .o_run, .o_reverse,
    .o_protect, .o_local, .o_local_indication, .o_speed_source, .o_run_source, .o_freq,
    .o_ramp_time, .o_speed_code, .o_jog, .o_passthru, .o_init_apply, .o_init_first_func,
    .o_init_second_func);
  always_comb begin
    for (int k = 0; k < 12; k++) i_func_codes[k*7+:7] = fc[k];
    vw = '{16'(o_run), 16'(o_reverse), 16'(o_protect), 16'(o_local), 16'(o_local_indication),
      16'(o_jog), o_freq, o_ramp_time, 16'(o_speed_source), 16'(o_run_source), 16'(o_passthru),
      16'(o_init_apply), 16'(o_init_first_func), 16'(o_init_second_func), 16'(o_speed_code)};
  end
  initial forever #4 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////
  task automatic ex(input logic [15:0] x, input int n);
    qe.push_back(x);
    qf.push_back(n);
  endtask
  // Two edges before the check: one for the contact model, one for the decoder; a third edge after it
  task automatic settle;
    repeat (2) @(posedge i_ref_clk);
    #1 -> look;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic do_reset(input logic p);
    i_power_on_run_permit = p;
    i_sys_rst = 1;
    repeat (5) @(posedge i_ref_clk);
    #1 i_sys_rst = 0;
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever begin
    @(look);
    while (qe.size() > 0) begin
      f = qf.pop_front();
      e = qe.pop_front();
      `CMP(vw[f], e)
    end
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int k = 0; k < 12; k++) fc[k] = k inside {[2:5]} ? FN_MS1 + 7'(k - 2) : FN_DIRECT;
    fc[0] = FN_FWD;
    fc[1] = FN_REV;
    fc[6] = 7'h0f;
    fc[7] = FN_SRC_SW;
    fc[8] = FN_JOG;
    for (int n = 0; n < 15; n++) i_preset_speed_table[n*16+:16] = 16'($random(seed));
    do_reset(1);
    for (int c = 0; c < 4; c++) begin
      pr[1:0] = 2'(c);
      pr[6] = c[1]; // Reserved code must change nothing
      ex(16'(c == 1 || c == 2), 0);
      if (c == 1 || c == 2) ex(16'(c == 2), 1);
      settle;
    end
    pr = 12'h001;
    do_reset(0);
    ex(1, 2);
    ex(0, 0);
    settle;
    pr = 0;
    ex(0, 2);
    settle;
    pr[0] = 1;
    do_reset(1);
    ex(1, 0);
    ex(0, 2);
    settle;
    $display("run and protect test done");
    fc[0] = FN_RUN2;
    fc[1] = FN_DIR2;
    for (int c = 0; c < 4; c++) begin
      pr[1:0] = 2'(c);
      ex(16'(c[0]), 0);
      if (c[0]) ex(16'(c[1]), 1);
      settle;
    end
    fc[0] = FN_FWD;
    fc[1] = FN_REV;
    pr = 0;
    for (int k = 0; k < 20; k++) begin
      r = k == 0 ? 5'h00 : 5'($random(seed));
      pr[5:2] = r[3:0];
      pr[8] = r[4];
      ex(r[4] ? i_jog_speed_preset : r[3:0] == 0 ? i_base_freq
        : i_preset_speed_table[(r[3:0]-1)*16+:16], 6);
      ex(!r[4] && r[3:0] != 0 ? i_multispeed_ramp_time : i_ramp_time_normal, 7);
      ex(16'(r[3:0]), 14);
      ex(16'(r[4]), 5);
      settle;
    end
    repeat (5) begin
      pr = 12'($random(seed)) & 12'he00;
      i_terminal_polarity_bits = 12'($random(seed)) & 12'he00;
      ex(16'((pr ^ i_terminal_polarity_bits) & 12'he00), 10);
      settle;
    end
    i_terminal_polarity_bits = 0;
    pr = 0;
    $display("speed and passthru test done");
    fc[9] = FN_THREE_WIRE;
    i_init_two_wire = 1;
    pr = 12'h202;
    ex(0, 0);
    ex(1, 1);
    ex(1, 11);
    ex(16'(FN_FWD), 12);
    ex(16'(FN_REV), 13);
    settle;
    pr = 12'h003;
    ex(0, 0);
    ex(0, 1);
    settle;
    pr = 12'h001;
    ex(0, 0);
    settle;
    fc[9] = FN_DIRECT;
    pr = 0;
    $display("three-wire and init test done");
    do_reset(1);
    i_local_remote_key = 1;
    ex(1, 3);
    ex(1, 4);
    settle;
    i_local_remote_key = 0;
    pr[0] = 1;
    settle;
    i_local_remote_key = 1;
    ex(1, 3);
    settle;
    i_local_remote_key = 0;
    pr = 0;
    do_reset(1);
    ex(i_speed_source_sel_a, 8);
    settle;
    pr[7] = 1;
    ex(i_speed_source_sel_b, 8);
    ex(i_run_source_sel_b, 9);
    settle;
    pr = 0;
    ex(i_speed_source_sel_a, 8);
    settle;
    pr = 12'h001;
    settle;
    pr[7] = 1;
    ex(i_speed_source_sel_a, 8);
    ex(i_run_source_sel_a, 9);
    settle;
    $display("mode and source test done");
    give_verdict;
  end
endmodule
